// ### rtl/oms_pkg.sv
package oms_pkg;
	// register byte addresses on the avalon slave
	localparam logic [4:0] ADDR_MODE_SELECT = 5'h00;
	localparam logic [4:0] ADDR_PANEL_FREQ = 5'h04;
	localparam logic [4:0] ADDR_OUT_FUNC = 5'h08;
	localparam logic [4:0] ADDR_STATUS = 5'h0c;
	localparam logic [4:0] ADDR_CMD_FREQ = 5'h10;

	// operation_mode_select settings
	localparam logic [2:0] MSEL_EXT_PU = 3'h0;
	localparam logic [2:0] MSEL_PU_FIXED = 3'h1;
	localparam logic [2:0] MSEL_EXT_FIXED = 3'h2;
	localparam logic [2:0] MSEL_COMB_PU_FREQ = 3'h3;
	localparam logic [2:0] MSEL_COMB_PU_START = 3'h4;
	localparam logic [2:0] MSEL_SWITCH = 3'h6;
	localparam logic [2:0] MSEL_RESET = 3'h0;

	// output terminal function codes
	localparam logic [7:0] FUNC_PU_POS = 8'h0a;
	localparam logic [7:0] FUNC_PU_NEG = 8'h6e;
	localparam logic [7:0] FUNC_RESET = 8'hff;
	localparam int FUNC_W = 8;

	// status register bit positions
	localparam int ST_MODE_LSB = 0;
	localparam int ST_FWD = 5;
	localparam int ST_REV = 6;
	localparam int ST_REJECT = 7;

	// remote link mode-change target
	localparam logic LINK_TO_EXT = 1'b0;
	localparam logic LINK_TO_NET = 1'b1;

	// operating mode, one-hot
	typedef enum logic [4:0] {
		MODE_EXT = 5'h01,
		MODE_PU = 5'h02,
		MODE_NET = 5'h04,
		MODE_COMB_PU_FREQ = 5'h08,
		MODE_COMB_PU_START = 5'h10
	} oms_mode_t;
endpackage

// ### rtl/oms_mode_selector.sv
`timescale 1ns/1ps

module oms_mode_selector #(
	parameter int FREQ_W = 16,
	parameter int NUM_OUT = 3
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// avalon-mm slave
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// control terminals
	input wire logic forwardStartInput,
	input wire logic reverseStartInput,
	input wire logic currentInputSelect,
	input wire logic [FREQ_W-1:0] term2Freq,
	input wire logic [FREQ_W-1:0] term4Freq,
	input wire logic multiSpeedOn,
	input wire logic [FREQ_W-1:0] multiSpeedFreq,
	input wire logic jogOn,
	input wire logic [FREQ_W-1:0] jogFreq,
	// operator panel, key strokes are one-cycle pulses
	input wire logic panelExternalToggleKey,
	input wire logic panelPuKey,
	input wire logic panelExtKey,
	input wire logic panelFwdKey,
	input wire logic panelRevKey,
	input wire logic panelStopKey,
	input wire logic panelFreqSet,
	input wire logic [FREQ_W-1:0] panelFreqIn,
	// remote link
	input wire logic linkModeReq,
	input wire logic linkModeTarget,
	input wire logic linkCmdSet,
	input wire logic linkFwd,
	input wire logic linkRev,
	input wire logic [FREQ_W-1:0] linkFreq,
	// drive command path
	output logic cmdFwd,
	output logic cmdRev,
	output logic [FREQ_W-1:0] cmdFreq,
	output logic [4:0] modeState,
	// output terminals
	output logic [NUM_OUT-1:0] panelModeIndicator
);

	// refuse widths the read mux and the function word cannot carry
	if (FREQ_W < 8 || FREQ_W > 24) begin : gBadFreqW
		$error("FREQ_W must lie in 8..24");
	end
	if (NUM_OUT < 1 || NUM_OUT > 4) begin : gBadNumOut
		$error("NUM_OUT must lie in 1..4");
	end

	////////////////////////////////////////////////////////////////////////
	// register state

	oms_pkg::oms_mode_t mode;
	logic [2:0] operationModeSelect;
	logic [FREQ_W-1:0] panelFreq;
	logic [NUM_OUT*oms_pkg::FUNC_W-1:0] outputTerminalFunctionParams;
	logic writeRejected;
	logic [1:0] panelRun;
	logic [1:0] linkRun;
	logic [FREQ_W-1:0] linkHeldFreq;

	////////////////////////////////////////////////////////////////////////
	// bus decode

	wire busReq = avs_read | avs_write;
	wire busTake = busReq & ~avs_waitrequest;
	wire wrTake = busTake & avs_write;
	wire hitModeSel = avs_address == oms_pkg::ADDR_MODE_SELECT;
	wire hitPanelFreq = avs_address == oms_pkg::ADDR_PANEL_FREQ;
	wire hitOutFunc = avs_address == oms_pkg::ADDR_OUT_FUNC;
	wire hitStatus = avs_address == oms_pkg::ADDR_STATUS;
	wire hitCmdFreq = avs_address == oms_pkg::ADDR_CMD_FREQ;
	wire [2:0] wrSel = avs_writedata[2:0];
	wire selValid = (wrSel != 3'h5) && (wrSel != 3'h7);
	wire modeSelWr = wrTake & hitModeSel & selValid;
	// mode select and status stay writable in external mode, panel frequency and output functions lock
	wire paramLocked = mode == oms_pkg::MODE_EXT;
	wire panelFreqWr = wrTake & hitPanelFreq & ~paramLocked;
	wire outFuncWr = wrTake & hitOutFunc & ~paramLocked;
	wire rejectEvent = wrTake & ((hitModeSel & ~selValid)
		| ((hitPanelFreq | hitOutFunc) & paramLocked));
	wire rejectClear = wrTake & hitStatus & avs_writedata[oms_pkg::ST_REJECT];

	wire [31:0] statusWord = {24'h0, writeRejected, cmdRev, cmdFwd, modeState};
	wire [31:0] readMux = hitModeSel ? {29'h0, operationModeSelect}
		: hitPanelFreq ? 32'(panelFreq)
		: hitOutFunc ? 32'(outputTerminalFunctionParams)
		: hitStatus ? statusWord
		: hitCmdFreq ? 32'(cmdFreq)
		: 32'h0;

	////////////////////////////////////////////////////////////////////////
	// mode switching

	// mode that a fresh setting starts in; 6 keeps a live panel or link mode
	function automatic oms_pkg::oms_mode_t startMode(input logic [2:0] sel,
		input oms_pkg::oms_mode_t cur);
		case (sel)
			oms_pkg::MSEL_PU_FIXED: startMode = oms_pkg::MODE_PU;
			oms_pkg::MSEL_COMB_PU_FREQ: startMode = oms_pkg::MODE_COMB_PU_FREQ;
			oms_pkg::MSEL_COMB_PU_START: startMode = oms_pkg::MODE_COMB_PU_START;
			oms_pkg::MSEL_SWITCH: startMode = (cur == oms_pkg::MODE_PU
				|| cur == oms_pkg::MODE_NET) ? cur : oms_pkg::MODE_EXT;
			default: startMode = oms_pkg::MODE_EXT;
		endcase
	endfunction

	wire inExt = mode == oms_pkg::MODE_EXT;
	wire inPu = mode == oms_pkg::MODE_PU;
	wire inNet = mode == oms_pkg::MODE_NET;
	wire selToggle = operationModeSelect == oms_pkg::MSEL_EXT_PU;
	wire selSwitch = operationModeSelect == oms_pkg::MSEL_SWITCH;
	// settings 1, 2, 3, 4 never enable any of these requests
	wire toggleReq = (selToggle | selSwitch) & panelExternalToggleKey
		& (inExt | inPu);
	wire puReq = selSwitch & panelPuKey & (inExt | inNet);
	wire extKeyReq = selSwitch & panelExtKey & inPu;
	wire linkNetReq = selSwitch & linkModeReq
		& (linkModeTarget == oms_pkg::LINK_TO_NET) & (inExt | inPu);
	wire linkExtReq = selSwitch & linkModeReq
		& (linkModeTarget == oms_pkg::LINK_TO_EXT) & inNet;

	// panel keys win over the link when both arrive together
	oms_pkg::oms_mode_t next_mode;
	assign next_mode = modeSelWr ? startMode(wrSel, mode)
		: toggleReq ? (inExt ? oms_pkg::MODE_PU : oms_pkg::MODE_EXT)
		: puReq ? oms_pkg::MODE_PU
		: extKeyReq ? oms_pkg::MODE_EXT
		: linkNetReq ? oms_pkg::MODE_NET
		: linkExtReq ? oms_pkg::MODE_EXT
		: mode;
	wire enterPu = (next_mode == oms_pkg::MODE_PU) & ~inPu;
	wire enterNet = (next_mode == oms_pkg::MODE_NET) & ~inNet;

	////////////////////////////////////////////////////////////////////////
	// command sources

	// both start inputs on at once is treated as stop
	wire [1:0] extRun = {reverseStartInput & ~forwardStartInput,
		forwardStartInput & ~reverseStartInput};
	wire [FREQ_W-1:0] analogFreq = currentInputSelect ? term4Freq : term2Freq;
	wire [FREQ_W-1:0] extFreq = jogOn ? jogFreq
		: multiSpeedOn ? multiSpeedFreq : analogFreq;
	wire [FREQ_W-1:0] combFreq = multiSpeedOn ? multiSpeedFreq
		: currentInputSelect ? term4Freq : panelFreq;

	logic [1:0] next_run;
	logic [FREQ_W-1:0] next_freq;
	assign next_run = (inExt | (mode == oms_pkg::MODE_COMB_PU_FREQ)) ? extRun
		: inNet ? linkRun
		: panelRun;
	assign next_freq = (inExt | (mode == oms_pkg::MODE_COMB_PU_START)) ? extFreq
		: inNet ? linkHeldFreq
		: inPu ? panelFreq
		: combFreq;

	// panel start keys act in the modes where the panel owns the start
	wire panelOwnsStart = inPu | (mode == oms_pkg::MODE_COMB_PU_START);
	wire panelOwnsFreq = inPu | (mode == oms_pkg::MODE_COMB_PU_FREQ);
	wire [1:0] next_panelRun = enterPu ? next_run
		: ~panelOwnsStart ? panelRun
		: panelStopKey ? 2'h0
		: panelFwdKey ? 2'h1
		: panelRevKey ? 2'h2
		: panelRun;
	// entry to panel mode copies the command in use; the panel dial comes next, bus writes last
	wire [FREQ_W-1:0] next_panelFreq = enterPu ? next_freq
		: (panelFreqSet & panelOwnsFreq) ? panelFreqIn
		: panelFreqWr ? avs_writedata[FREQ_W-1:0]
		: panelFreq;

	////////////////////////////////////////////////////////////////////////
	// bus slave: one wait cycle, then the request is taken

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0;
		end else begin
			avs_waitrequest <= ~(busReq & avs_waitrequest);
			avs_readdata <= readMux;
		end
	end

	// software registers; reject flag set wins over its clear
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			operationModeSelect <= oms_pkg::MSEL_RESET;
			outputTerminalFunctionParams <= {NUM_OUT{oms_pkg::FUNC_RESET}};
			writeRejected <= 1'b0;
		end else begin
			if (modeSelWr) begin
				operationModeSelect <= wrSel;
			end
			if (outFuncWr) begin
				outputTerminalFunctionParams <= avs_writedata[NUM_OUT*oms_pkg::FUNC_W-1:0];
			end
			writeRejected <= rejectEvent | (writeRejected & ~rejectClear);
		end
	end

	// mode register and retained commands; reset drops what was held
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			mode <= oms_pkg::MODE_EXT;
			panelRun <= 2'h0;
			panelFreq <= '0;
			linkRun <= 2'h0;
			linkHeldFreq <= '0;
		end else begin
			mode <= next_mode;
			panelRun <= next_panelRun;
			panelFreq <= next_panelFreq;
			if (enterNet) begin
				linkRun <= next_run;
				linkHeldFreq <= next_freq;
			end else if (inNet & linkCmdSet) begin
				linkRun <= {linkRev & ~linkFwd, linkFwd & ~linkRev};
				linkHeldFreq <= linkFreq;
			end
		end
	end

	// command path to the drive, one cycle behind the sources
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			cmdFwd <= 1'b0;
			cmdRev <= 1'b0;
			cmdFreq <= '0;
			modeState <= 5'h01;
		end else begin
			cmdFwd <= next_run[0];
			cmdRev <= next_run[1];
			cmdFreq <= next_freq;
			modeState <= next_mode;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// output terminals carrying the panel mode indicator

	for (genvar i = 0; i < NUM_OUT; i++) begin : gTerm
		wire [7:0] code = outputTerminalFunctionParams[i*oms_pkg::FUNC_W +: oms_pkg::FUNC_W];
		wire next_ind = (code == oms_pkg::FUNC_PU_POS) ? (next_mode == oms_pkg::MODE_PU)
			: (code == oms_pkg::FUNC_PU_NEG) ? (next_mode != oms_pkg::MODE_PU)
			: 1'b0;
		always_ff @(posedge ref_clk or negedge resetn) begin
			if (!resetn) begin
				panelModeIndicator[i] <= 1'b0;
			end else begin
				panelModeIndicator[i] <= next_ind;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	a_ext_locked: assert property (@(posedge ref_clk) disable iff (!resetn)
		operationModeSelect == oms_pkg::MSEL_EXT_FIXED |-> mode == oms_pkg::MODE_EXT)
		else $error("setting 2 left external mode");

	a_pu_fixed: assert property (@(posedge ref_clk) disable iff (!resetn)
		operationModeSelect == oms_pkg::MSEL_PU_FIXED |-> mode == oms_pkg::MODE_PU)
		else $error("setting 1 left panel mode");

	a_comb_fixed: assert property (@(posedge ref_clk) disable iff (!resetn)
		(operationModeSelect == oms_pkg::MSEL_COMB_PU_FREQ
		|-> mode == oms_pkg::MODE_COMB_PU_FREQ)
		and (operationModeSelect == oms_pkg::MSEL_COMB_PU_START
		|-> mode == oms_pkg::MODE_COMB_PU_START))
		else $error("combined setting left its mode");

	a_toggle_key: assert property (@(posedge ref_clk) disable iff (!resetn)
		selToggle && panelExternalToggleKey && inExt && !modeSelWr
		|=> mode == oms_pkg::MODE_PU ##1 modeState == oms_pkg::MODE_PU)
		else $error("toggle key did not reach panel mode");

	a_ext_write_block: assert property (@(posedge ref_clk) disable iff (!resetn)
		wrTake && hitOutFunc && inExt
		|=> $stable(outputTerminalFunctionParams) && writeRejected)
		else $error("register write landed in external mode");

	a_ext_term2: assert property (@(posedge ref_clk) disable iff (!resetn)
		inExt && !jogOn && !multiSpeedOn && !currentInputSelect
		|=> cmdFreq == $past(term2Freq))
		else $error("external frequency not from terminal 2");

	a_comb_multispeed: assert property (@(posedge ref_clk) disable iff (!resetn)
		mode == oms_pkg::MODE_COMB_PU_FREQ && multiSpeedOn
		|=> cmdFreq == $past(multiSpeedFreq))
		else $error("multispeed did not override panel frequency");

	a_comb_term4: assert property (@(posedge ref_clk) disable iff (!resetn)
		mode == oms_pkg::MODE_COMB_PU_FREQ && !multiSpeedOn && currentInputSelect
		|=> cmdFreq == $past(term4Freq))
		else $error("current input select ignored");

	a_pu_indicator: assert property (@(posedge ref_clk) disable iff (!resetn)
		inPu && $stable(mode) && $stable(outputTerminalFunctionParams)
		&& outputTerminalFunctionParams[7:0] == oms_pkg::FUNC_PU_POS
		|-> panelModeIndicator[0])
		else $error("panel indicator low in panel mode");

	a_pu_entry_keep: assert property (@(posedge ref_clk) disable iff (!resetn)
		enterPu && !modeSelWr ##1 !panelFreqSet && !panelFreqWr && !panelStopKey
		&& !panelFwdKey && !panelRevKey
		|=> cmdFreq == $past(cmdFreq) && cmdFwd == $past(cmdFwd) && cmdRev == $past(cmdRev))
		else $error("command changed on entry to panel mode");

	a_net_entry_keep: assert property (@(posedge ref_clk) disable iff (!resetn)
		enterNet ##1 !linkCmdSet
		|=> cmdFreq == $past(cmdFreq) && cmdFwd == $past(cmdFwd))
		else $error("command changed on entry to link mode");

	a_bus_answer: assert property (@(posedge ref_clk) disable iff (!resetn)
		busReq && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("waitrequest not low for exactly one cycle");

	a_mode_onehot: assert property (@(posedge ref_clk) disable iff (!resetn)
		$onehot(mode) && modeState == mode)
		else $error("mode register not one-hot or not mirrored");

	a_freq_write_block: assert property (@(posedge ref_clk) disable iff (!resetn)
		wrTake && hitPanelFreq && inExt && !enterPu |=> $stable(panelFreq) && writeRejected)
		else $error("panel frequency write landed in external mode");

	a_reject_set: assert property (@(posedge ref_clk) disable iff (!resetn)
		rejectEvent |=> writeRejected)
		else $error("refused write did not set the flag");

	a_ext_key: assert property (@(posedge ref_clk) disable iff (!resetn)
		extKeyReq && !modeSelWr |=> inExt)
		else $error("external key did not leave panel mode");

	a_net_to_pu: assert property (@(posedge ref_clk) disable iff (!resetn)
		puReq && inNet && !modeSelWr
		|=> inPu && panelFreq == $past(linkHeldFreq) && panelRun == $past(linkRun))
		else $error("link command lost on entry to panel mode");

	a_link_refused: assert property (@(posedge ref_clk) disable iff (!resetn)
		linkModeReq && !selSwitch && !modeSelWr && !panelExternalToggleKey |=> $stable(mode))
		else $error("link request honoured outside the switch-over setting");

endmodule

// ### verif/oms_far_model.sv
`timescale 1ns/1ps

// operator panel and remote link master; released data lines are inverted
module oms_far_model (
	// clock
	input wire logic ref_clk,
	// operator panel
	output logic panelExternalToggleKey,
	output logic panelPuKey,
	output logic panelExtKey,
	output logic panelFwdKey,
	output logic panelRevKey,
	output logic panelStopKey,
	output logic panelFreqSet,
	output logic [15:0] panelFreqIn,
	// remote link
	output logic linkModeReq,
	output logic linkModeTarget,
	output logic linkCmdSet,
	output logic linkFwd,
	output logic linkRev,
	output logic [15:0] linkFreq
);
	logic [5:0] keys;

	// key strokes are one-cycle pulses, bit 0 first: toggle, pu, ext, fwd, rev, stop
	assign {panelStopKey, panelRevKey, panelFwdKey, panelExtKey, panelPuKey,
		panelExternalToggleKey} = keys;

	// toggle key, dial and link lines are pulsed once while the device sits in reset, then rest released
	initial begin
		fork
			press(0);
			dial(16'h0000);
			link_mode(1'b0);
			link_cmd(1'b0, 1'b0, 16'h0000);
		join
	end
////////////////////////////////////////
	task automatic press(input int k);
		@(posedge ref_clk);
		keys <= 6'h01 << k;
		@(posedge ref_clk);
		keys <= 6'h00;
	endtask

	// the dial value only counts with its set pulse, so it is scrambled after
	task automatic dial(input logic [15:0] f);
		@(posedge ref_clk);
		panelFreqSet <= 1'b1;
		panelFreqIn <= f;
		@(posedge ref_clk);
		panelFreqSet <= 1'b0;
		panelFreqIn <= ~f;
	endtask

	// mode change command sent by the link master
	task automatic link_mode(input logic tgt);
		@(posedge ref_clk);
		linkModeReq <= 1'b1;
		linkModeTarget <= tgt;
		@(posedge ref_clk);
		linkModeReq <= 1'b0;
		linkModeTarget <= ~tgt;
	endtask

	// new run command over the link
	task automatic link_cmd(input logic f, input logic r, input logic [15:0] q);
		@(posedge ref_clk);
		linkCmdSet <= 1'b1;
		{linkFwd, linkRev, linkFreq} <= {f, r, q};
		@(posedge ref_clk);
		linkCmdSet <= 1'b0;
		{linkFwd, linkRev, linkFreq} <= ~{f, r, q};
	endtask
endmodule

// ### verif/testbench.sv
`timescale 1ns/1ps

// self-checking bench for the operation mode selector
module testbench;
	logic ref_clk, resetn, avs_read, avs_write, avs_waitrequest;
	logic [4:0] avs_address, modeState;
	logic [31:0] avs_writedata, avs_readdata;
	logic forwardStartInput, reverseStartInput, currentInputSelect, multiSpeedOn, jogOn;
	logic [15:0] term2Freq, term4Freq, multiSpeedFreq, jogFreq, panelFreqIn, linkFreq, cmdFreq;
	logic panelExternalToggleKey, panelPuKey, panelExtKey, panelFwdKey, panelRevKey;
	logic panelStopKey, panelFreqSet, linkModeReq, linkModeTarget, linkCmdSet, linkFwd, linkRev;
	logic cmdFwd, cmdRev;
	logic [2:0] panelModeIndicator;
	logic [31:0] q;
	int errorCnt, samplesChecked;

	oms_mode_selector #(.FREQ_W(16), .NUM_OUT(3)) dut (
		.ref_clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_readdata, .avs_waitrequest, .forwardStartInput, .reverseStartInput,
		.currentInputSelect, .term2Freq, .term4Freq, .multiSpeedOn, .multiSpeedFreq,
		.jogOn, .jogFreq, .panelExternalToggleKey, .panelPuKey, .panelExtKey,
		.panelFwdKey, .panelRevKey, .panelStopKey, .panelFreqSet, .panelFreqIn,
		.linkModeReq, .linkModeTarget, .linkCmdSet, .linkFwd, .linkRev, .linkFreq,
		.cmdFwd, .cmdRev, .cmdFreq, .modeState, .panelModeIndicator
	);
	oms_far_model fm (
		.ref_clk, .panelExternalToggleKey, .panelPuKey, .panelExtKey, .panelFwdKey,
		.panelRevKey, .panelStopKey, .panelFreqSet, .panelFreqIn, .linkModeReq,
		.linkModeTarget, .linkCmdSet, .linkFwd, .linkRev, .linkFreq
	);

	// 20 MHz clock
	always #25 ref_clk = ~ref_clk;
////////////////////////////////////////
	task automatic reportAndStop();
		if (errorCnt == 0 && samplesChecked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samplesChecked++;
		if (g !== e) begin
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
			errorCnt++;
		end
	endtask

	// master holds the request until it samples waitrequest low
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		int n;
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= ~wr;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 16);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (avs_waitrequest !== 1'b0) begin
			$display("wrong value at %0t: bus timeout", $time);
			errorCnt++;
			reportAndStop();
		end
	endtask

	task automatic rdc(input logic [4:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(q, e);
	endtask

	task automatic term(input logic f, r, au, ms, jg, input logic [15:0] t2);
		@(posedge ref_clk);
		{forwardStartInput, reverseStartInput, currentInputSelect} <= {f, r, au};
		{multiSpeedOn, jogOn, term2Freq} <= {ms, jg, t2};
	endtask

	// terminal 4, multispeed and jog values
	task automatic srcs(input logic [15:0] t4, ms, jg);
		@(posedge ref_clk);
		{term4Freq, multiSpeedFreq, jogFreq} <= {t4, ms, jg};
	endtask

	// mode lands one edge after a request, commands one edge later still
	task automatic cc(input logic f, r, input logic [15:0] q, input oms_pkg::oms_mode_t m);
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk);
		chk({9'h000, modeState, cmdFwd, cmdRev, cmdFreq}, {9'h000, m, f, r, q});
	endtask

	task automatic ind(input logic [2:0] e);
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk);
		chk({29'h0, panelModeIndicator}, {29'h0, e});
	endtask
////////////////////////////////////////
	task automatic s_reset();
		cc(1'b0, 1'b0, 16'h0, oms_pkg::MODE_EXT);
		rdc(oms_pkg::ADDR_MODE_SELECT, 32'h0);
		rdc(oms_pkg::ADDR_OUT_FUNC, 32'h00ffffff);
		ind(3'b000);
	endtask

	task automatic s_ext();
		srcs(16'h0445, 16'h0556, 16'h0667);
		term(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0222);
		cc(1'b1, 1'b0, 16'h0222, oms_pkg::MODE_EXT);
		rdc(oms_pkg::ADDR_CMD_FREQ, 32'h0222);
		term(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 16'h0222);
		cc(1'b0, 1'b1, 16'h0445, oms_pkg::MODE_EXT);
		term(1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 16'h0222);
		cc(1'b0, 1'b1, 16'h0556, oms_pkg::MODE_EXT);
		term(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 16'h0222);
		cc(1'b0, 1'b0, 16'h0667, oms_pkg::MODE_EXT);
		srcs(16'h0444, 16'h0555, 16'h0666);
	endtask

	// panel frequency and bad mode codes are refused, the flag clears on a 1
	task automatic s_reject();
		term(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0);
		bus(1'b1, oms_pkg::ADDR_PANEL_FREQ, 32'h1111);
		bus(1'b1, oms_pkg::ADDR_OUT_FUNC, 32'h00000a0a);
		rdc(oms_pkg::ADDR_PANEL_FREQ, 32'h0);
		rdc(oms_pkg::ADDR_OUT_FUNC, 32'h00ffffff);
		rdc(oms_pkg::ADDR_STATUS, 32'h81);
		bus(1'b1, oms_pkg::ADDR_STATUS, 32'h80);
		rdc(oms_pkg::ADDR_STATUS, 32'h01);
		bus(1'b1, oms_pkg::ADDR_MODE_SELECT, 32'h5);
		rdc(oms_pkg::ADDR_MODE_SELECT, 32'h0);
		rdc(oms_pkg::ADDR_STATUS, 32'h81);
		bus(1'b1, oms_pkg::ADDR_STATUS, 32'h80);
		rdc(5'h14, 32'h0);
	endtask

	task automatic s_toggle();
		term(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0300);
		fm.press(0);
		cc(1'b1, 1'b0, 16'h0300, oms_pkg::MODE_PU);
		term(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 16'h0aaa);
		cc(1'b1, 1'b0, 16'h0300, oms_pkg::MODE_PU);
		bus(1'b1, oms_pkg::ADDR_OUT_FUNC, 32'h00ff6e0a);
		ind(3'b001);
		fm.press(4);
		fm.dial(16'h0777);
		cc(1'b0, 1'b1, 16'h0777, oms_pkg::MODE_PU);
		fm.press(0);
		cc(1'b0, 1'b1, 16'h0aaa, oms_pkg::MODE_EXT);
		ind(3'b010);
	endtask

	// fixed settings ignore the toggle key, the external key and a link request to external mode
	task automatic s_fixed();
		bus(1'b1, oms_pkg::ADDR_MODE_SELECT, 32'h2);
		fm.press(0);
		cc(1'b0, 1'b1, 16'h0aaa, oms_pkg::MODE_EXT);
		bus(1'b1, oms_pkg::ADDR_MODE_SELECT, 32'h1);
		fm.press(0);
		fm.press(2);
		fm.link_mode(1'b0);
		cc(1'b0, 1'b1, 16'h0aaa, oms_pkg::MODE_PU);
	endtask

	task automatic s_comb();
		bus(1'b1, oms_pkg::ADDR_MODE_SELECT, 32'h3);
		fm.dial(16'h0123);
		term(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0aaa);
		fm.press(0);
		cc(1'b1, 1'b0, 16'h0123, oms_pkg::MODE_COMB_PU_FREQ);
		term(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 16'h0aaa);
		cc(1'b1, 1'b0, 16'h0555, oms_pkg::MODE_COMB_PU_FREQ);
		term(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 16'h0aaa);
		cc(1'b0, 1'b1, 16'h0444, oms_pkg::MODE_COMB_PU_FREQ);
		bus(1'b1, oms_pkg::ADDR_MODE_SELECT, 32'h4);
		term(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0abc);
		fm.press(3);
		cc(1'b1, 1'b0, 16'h0abc, oms_pkg::MODE_COMB_PU_START);
		term(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 16'h0abc);
		fm.press(0);
		cc(1'b1, 1'b0, 16'h0666, oms_pkg::MODE_COMB_PU_START);
	endtask

	// switch-over while running through every documented transition except the toggle key
	task automatic s_switch();
		bus(1'b1, oms_pkg::ADDR_MODE_SELECT, 32'h6);
		term(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0321);
		fm.link_mode(1'b1);
		term(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 16'h0999);
		cc(1'b1, 1'b0, 16'h0321, oms_pkg::MODE_NET);
		fm.link_cmd(1'b0, 1'b1, 16'h0456);
		fm.press(1);
		cc(1'b0, 1'b1, 16'h0456, oms_pkg::MODE_PU);
		fm.dial(16'h0654);
		fm.link_mode(1'b1);
		cc(1'b0, 1'b1, 16'h0654, oms_pkg::MODE_NET);
		fm.link_mode(1'b0);
		cc(1'b0, 1'b1, 16'h0999, oms_pkg::MODE_EXT);
		term(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0888);
		fm.press(1);
		term(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 16'h0777);
		cc(1'b1, 1'b0, 16'h0888, oms_pkg::MODE_PU);
		fm.press(2);
		cc(1'b0, 1'b1, 16'h0777, oms_pkg::MODE_EXT);
	endtask

	// reset in mid-run drops the retained command and the setting
	task automatic s_reset_mid();
		fm.press(1);
		@(posedge ref_clk);
		resetn <= 1'b0;
		@(negedge ref_clk);
		chk({modeState, cmdFwd, cmdRev, cmdFreq}, {oms_pkg::MODE_EXT, 18'h0});
		@(posedge ref_clk);
		resetn <= 1'b1;
		rdc(oms_pkg::ADDR_MODE_SELECT, 32'h0);
		rdc(oms_pkg::ADDR_PANEL_FREQ, 32'h0);
		fm.press(0);
		cc(1'b0, 1'b1, 16'h0777, oms_pkg::MODE_PU);
	endtask

	// time-zero values, reset for six cycles, then the scenarios
	initial begin
		ref_clk = 1'b0;
		resetn = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		errorCnt = 0;
		samplesChecked = 0;
		// terminals settle during reset; address and data wait for the first access
		term(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0);
		srcs(16'h0444, 16'h0555, 16'h0666);
		repeat (4) @(posedge ref_clk);
		resetn <= 1'b1;
		s_reset();
		s_ext();
		s_reject();
		s_toggle();
		s_fixed();
		s_comb();
		s_switch();
		s_reset_mid();
		reportAndStop();
	end
endmodule
